// *** inc/eeprom_port_pkg.sv ***
`default_nettype none
package eeprom_port_pkg;
  // ----------------------------------------
  // Identity
  // ----------------------------------------
  // Device type code, arbitrary value
  localparam logic [3:0] DEVICE_TYPE_CODE = 4'h5;
  // ----------------------------------------
  // Array geometry
  // ----------------------------------------
  localparam int         MEM_DEPTH  = 128;
  localparam int         PAGE_BYTES = 8;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [6:0] TX_ADDR_START = 7'h00;
  // ----------------------------------------
  // Bit slots within a byte frame
  // ----------------------------------------
  localparam logic [3:0] BYTE_DONE = 4'h8;
  localparam logic [3:0] ACK_DONE  = 4'h9;
  localparam logic [3:0] NULL_BIT  = 4'h8;
  localparam logic [3:0] SYNC_CLOCKS = 4'h9;
  // ----------------------------------------
  // Write cycle timing
  // ----------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int WRITE_TIME_MS = 10;
  localparam int WRITE_CYCLES  = WRITE_TIME_MS * (CLK_HZ / 1000);
  localparam int TIMER_W       = 20;
endpackage
`default_nettype wire

// *** logic/eeprom_dual_mode_port.sv ***
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - Data changes only while SCL low
// - Receiver drives ACK on ninth clock
// - Master NACK ends read, SDA released
// - Control byte: code, three ignored bits, direction
// - ACK control only on match, not busy
// - Byte write: control, address, data, STOP
// - STOP after data starts write, no ACKs
// - Up to eight bytes buffered until STOP
// - Writes increment only low three pointer bits
// - Excess bytes overwrite oldest buffered ones
// - Program only with protect input high
// - Protect input low blocks all writes
// - Current read returns last address plus one
// - Repeated START keeps new pointer, drops write
// - Master ACK increments pointer, next byte
// - SCL falling edge enters bidirectional mode
// - Transmit-only: one bit per clock rise
// - MSB first, null bit, ascending, wraps
// - Nine clocks absorbed, data on tenth
// - Bidirectional mode sticks until reset
module eeprom_dual_mode_port #(
  parameter int WRITE_CYCLES = eeprom_port_pkg::WRITE_CYCLES
) (
  // System
  input  wire logic clk_in,
  input  wire logic reset_in,
  // Two-wire bus, SDA open drain
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n_out,
  // Transmit-only clock, write protect level
  input  wire logic transmit_only_clock_in,
  // Status
  output logic      bidir_mode_out,
  output logic      write_busy_out
);

  // ----------------------------------------
  // Types and storage
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_CTRL  = 5'h02,
    ST_ADDR  = 5'h04,
    ST_WDATA = 5'h08,
    ST_RDATA = 5'h10
  } state_t;

  // Memory array
  logic [7:0] mem [0:eeprom_port_pkg::MEM_DEPTH-1];
  // Page buffer and filled-slot mask
  logic [7:0] page_buf [0:eeprom_port_pkg::PAGE_BYTES-1];
  logic [7:0] page_mask;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic scl_meta;   // First stage
  logic scl_s;      // Synchronised SCL
  logic scl_d;      // Previous SCL
  logic sda_meta;   // First stage
  logic sda_s;      // Synchronised SDA
  logic sda_d;      // Previous SDA
  logic wp_meta;    // First stage
  logic wp_level;   // Protect level

  // Two flops per pin, third for edges
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      scl_meta <= 1'h1;
      scl_s    <= 1'h1;
      scl_d    <= 1'h1;
      sda_meta <= 1'h1;
      sda_s    <= 1'h1;
      sda_d    <= 1'h1;
      wp_meta  <= 1'h0;
      wp_level <= 1'h0;
    end else begin
      scl_meta <= scl_in;
      scl_s    <= scl_meta;
      scl_d    <= scl_s;
      sda_meta <= sda_in;
      sda_s    <= sda_meta;
      sda_d    <= sda_s;
      wp_meta  <= transmit_only_clock_in;
      wp_level <= wp_meta;
    end
  end

  // ----------------------------------------
  // Mode switch
  // ----------------------------------------
  logic bidir_mode; // Sticky mode flag
  logic scl_fall;   // Any SCL fall

  assign scl_fall = scl_d & ~scl_s;

  // Leave transmit-only on first SCL fall
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      bidir_mode <= 1'h0;
    end else if (scl_fall) begin
      bidir_mode <= 1'h1;
    end
  end

  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  logic start_cond; // START seen
  logic stop_cond;  // STOP seen
  logic bit_rise;   // Data clock rise
  logic bit_fall;   // Data clock fall

  // SDA edges with SCL high are conditions
  assign start_cond = bidir_mode & scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = bidir_mode & scl_s & scl_d & ~sda_d & sda_s;
  assign bit_rise   = bidir_mode & scl_s & ~scl_d;
  assign bit_fall   = bidir_mode & scl_fall;

  // ----------------------------------------
  // Byte engine
  // ----------------------------------------
  state_t     state;      // Protocol phase
  logic [3:0] bit_cnt;    // Clock rises in byte
  logic [7:0] shift;      // Received byte
  logic [7:0] tx_byte;    // Byte being sent
  logic [6:0] addr;       // Address pointer
  logic       drive_low;  // Pull SDA low
  logic       master_ack; // Master wants more
  logic       busy;       // Write cycle active
  logic       byte_done;  // Fall after 8th bit
  logic       ack_end;    // Fall after ack bit
  logic       ctrl_match; // Control accepted
  logic       wr_byte;    // Data byte taken
  logic       rd_load;    // Next read byte
  logic       launch;     // Start write cycle

  assign byte_done  = bit_fall & (bit_cnt == eeprom_port_pkg::BYTE_DONE);
  assign ack_end    = bit_fall & (bit_cnt == eeprom_port_pkg::ACK_DONE);
  // Type code must match and array idle
  assign ctrl_match = (shift[7:4] == eeprom_port_pkg::DEVICE_TYPE_CODE)
                      & ~busy;
  assign wr_byte    = byte_done & (state == ST_WDATA);
  assign rd_load    = ack_end & (state == ST_RDATA) & master_ack;
  // Only a STOP after data, with protect high
  assign launch     = stop_cond & (state == ST_WDATA)
                      & (|page_mask) & wp_level;

  // Phase, bit count and SDA drive
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      drive_low  <= 1'h0;
      master_ack <= 1'h0;
    end else if (start_cond) begin
      // Any START, repeated or not
      state     <= ST_CTRL;
      bit_cnt   <= 4'h0;
      drive_low <= 1'h0;
    end else if (stop_cond) begin
      state     <= ST_IDLE;
      drive_low <= 1'h0;
    end else if (state != ST_IDLE) begin
      if (bit_rise) begin
        // One bit per clock pulse
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt == eeprom_port_pkg::BYTE_DONE) begin
          master_ack <= ~sda_s;
        end else if (state != ST_RDATA) begin
          shift <= {shift[6:0], sda_s};
        end
      end else if (byte_done) begin
        if (state == ST_RDATA) begin
          // Let master answer
          drive_low <= 1'h0;
        end else if (state == ST_CTRL) begin
          if (ctrl_match) begin
            drive_low  <= 1'h1;
            master_ack <= 1'h1;
            state      <= shift[0] ? ST_RDATA : ST_ADDR;
          end else begin
            state <= ST_IDLE;
          end
        end else begin
          // Address or data byte
          drive_low <= 1'h1;
          if (state == ST_ADDR) begin
            state <= ST_WDATA;
          end
        end
      end else if (ack_end) begin
        bit_cnt <= 4'h0;
        if (state != ST_RDATA) begin
          drive_low <= 1'h0;
        end else if (master_ack) begin
          drive_low <= ~mem[addr][7];
        end else begin
          // No ACK: release and wait
          state     <= ST_IDLE;
          drive_low <= 1'h0;
        end
      end else if (bit_fall && state == ST_RDATA) begin
        // Next bit, MSB first
        drive_low <= ~tx_byte[3'h7 - bit_cnt[2:0]];
      end
    end
  end

  // ----------------------------------------
  // Address pointer
  // ----------------------------------------
  // Load, page increment, read increment
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      addr    <= eeprom_port_pkg::ADDR_RESET;
      tx_byte <= 8'h00;
    end else if (byte_done && state == ST_ADDR) begin
      addr <= shift[6:0];
    end else if (wr_byte) begin
      addr <= {addr[6:3], addr[2:0] + 3'h1};
    end else if (rd_load) begin
      tx_byte <= mem[addr];
      addr    <= addr + 7'h1;
    end
  end

  // ----------------------------------------
  // Page buffer
  // ----------------------------------------
  // Collect data; START or STOP empties it
  always_ff @(posedge clk_in) begin
    if (reset_in || start_cond || stop_cond) begin
      page_mask <= 8'h00;
    end else if (wr_byte) begin
      page_buf[addr[2:0]]  <= shift;
      page_mask[addr[2:0]] <= 1'h1;
    end
  end

  // Commit filled slots at launch
  always_ff @(posedge clk_in) begin
    if (launch) begin
      for (int i = 0; i < eeprom_port_pkg::PAGE_BYTES; i++) begin
        if (page_mask[i]) begin
          mem[{addr[6:3], 3'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Write cycle timer
  // ----------------------------------------
  logic [eeprom_port_pkg::TIMER_W-1:0] timer; // Cycles left

  // Busy for the write time, protect ignored
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      busy  <= 1'h0;
      timer <= '0;
    end else if (launch) begin
      busy  <= 1'h1;
      timer <= eeprom_port_pkg::TIMER_W'(WRITE_CYCLES - 1);
    end else if (busy) begin
      if (timer == '0) begin
        busy <= 1'h0;
      end else begin
        timer <= timer - 1'h1;
      end
    end
  end

  // ----------------------------------------
  // Transmit-only link domain
  // ----------------------------------------
  logic       vrst_meta; // Reset first stage
  logic       vrst;      // Link-side reset
  logic       mode_meta; // Mode first stage
  logic       mode_v;    // Mode, link side
  logic [3:0] sync_cnt;  // Absorbed clocks
  logic [3:0] tx_bit;    // Bit slot in frame
  logic [6:0] tx_addr;   // Stream address
  logic       tx_drive;  // Pull SDA low

  // Reset and mode cross into link clock
  always_ff @(posedge transmit_only_clock_in) begin
    vrst_meta <= reset_in;
    vrst      <= vrst_meta;
    if (vrst) begin
      mode_meta <= 1'h0;
      mode_v    <= 1'h0;
    end else begin
      mode_meta <= bidir_mode;
      mode_v    <= mode_meta;
    end
  end

  // Stream the array; it is static here
  always_ff @(posedge transmit_only_clock_in) begin
    if (vrst) begin
      sync_cnt <= 4'h0;
      tx_bit   <= 4'h0;
      tx_addr  <= eeprom_port_pkg::TX_ADDR_START;
      tx_drive <= 1'h0;
    end else if (mode_v) begin
      tx_drive <= 1'h0;
    end else if (sync_cnt != eeprom_port_pkg::SYNC_CLOCKS) begin
      sync_cnt <= sync_cnt + 4'h1;
    end else begin
      // Null slot releases the line
      tx_drive <= (tx_bit != eeprom_port_pkg::NULL_BIT)
                  & ~mem[tx_addr][3'h7 - tx_bit[2:0]];
      if (tx_bit == eeprom_port_pkg::NULL_BIT) begin
        tx_bit  <= 4'h0;
        tx_addr <= tx_addr + 7'h1;
      end else begin
        tx_bit <= tx_bit + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sda_out        = 1'h0;
  assign sda_oe_n_out   = ~(bidir_mode ? drive_low : tx_drive);
  assign bidir_mode_out = bidir_mode;
  assign write_busy_out = busy;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  property p_start_ctrl;
    start_cond |=> (state == ST_CTRL) && (bit_cnt == 4'h0) && !drive_low;
  endproperty
  a_start_ctrl: assert property (p_start_ctrl)
    else $error("START did not open control phase");

  property p_stop_idle;
    stop_cond |=> (state == ST_IDLE) && !drive_low;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("STOP did not return to idle");

  property p_no_ack_busy;
    (byte_done && state == ST_CTRL && busy) |=> !drive_low && state == ST_IDLE;
  endproperty
  a_no_ack_busy: assert property (p_no_ack_busy)
    else $error("Control byte acknowledged while busy");

  property p_bad_code;
    (byte_done && state == ST_CTRL
     && shift[7:4] != eeprom_port_pkg::DEVICE_TYPE_CODE) |=> !drive_low;
  endproperty
  a_bad_code: assert property (p_bad_code)
    else $error("Foreign control byte acknowledged");

  property p_page_wrap;
    wr_byte |=> addr[6:3] == $past(addr[6:3])
                && addr[2:0] == $past(addr[2:0]) + 3'h1;
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("Pointer left its page");

  property p_protect;
    $rose(busy) |-> $past(wp_level) && $past(stop_cond);
  endproperty
  a_protect: assert property (p_protect)
    else $error("Write started without protect high");

  property p_busy_hold;
    $rose(busy) |-> busy [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("Write cycle ended early");

  property p_busy_end;
    (busy && timer == '0 && !launch) |=> !busy;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("Write cycle overran");

  property p_mode_sticky;
    bidir_mode |=> bidir_mode;
  endproperty
  a_mode_sticky: assert property (p_mode_sticky)
    else $error("Left bidirectional mode");

  property p_mode_enter;
    scl_fall |=> bidir_mode;
  endproperty
  a_mode_enter: assert property (p_mode_enter)
    else $error("SCL fall did not switch mode");

  property p_nack_release;
    (ack_end && state == ST_RDATA && !master_ack)
      |=> state == ST_IDLE ##1 sda_oe_n_out;
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("SDA held after master NACK");

  property p_seq_inc;
    rd_load |=> addr == $past(addr) + 7'h1 && tx_byte == $past(mem[addr]);
  endproperty
  a_seq_inc: assert property (p_seq_inc)
    else $error("Read pointer did not advance");

  property p_sync_quiet;
    @(posedge transmit_only_clock_in) disable iff (vrst)
      (sync_cnt != eeprom_port_pkg::SYNC_CLOCKS) |=> !tx_drive;
  endproperty
  a_sync_quiet: assert property (p_sync_quiet)
    else $error("SDA driven during synchronisation");

  c_launch:    cover property (launch);
  c_poll_nack: cover property (byte_done && state == ST_CTRL && busy);
  c_seq_read:  cover property (rd_load ##[1:400] rd_load);
  c_mode:      cover property ($rose(bidir_mode));

endmodule
`default_nettype wire

// *** verif/two_wire_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model (
  // Pacing clock
  input  wire logic clk_in,
  // Resolved data wire level
  input  wire logic sda_in,
  // Bus drive, data is open drain
  output logic      scl_out,
  output logic      sda_low_out
);
  // ----------------------------------------
  // Pacing
  // ----------------------------------------
  int extra;  // Stretch of each bit phase, slow master

  // Idle bus at time zero
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
    extra       = 0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // ----------------------------------------
  // Conditions
  // ----------------------------------------
  // Start or repeated start: data falls while clock high
  task automatic start();
    sda_low_out = 1'b0;
    wait_clk(5);
    scl_out = 1'b1;
    wait_clk(10);
    sda_low_out = 1'b1;
    wait_clk(10);
    scl_out = 1'b0;
    wait_clk(5);
  endtask

  // Stop: data rises while clock high
  task automatic stop();
    sda_low_out = 1'b1;
    wait_clk(5);
    scl_out = 1'b1;
    wait_clk(10);
    sda_low_out = 1'b0;
    wait_clk(10);
  endtask

  // Single clock dip, leaves clock high
  task automatic pulse_scl();
    scl_out = 1'b0;
    wait_clk(10);
    scl_out = 1'b1;
    wait_clk(10);
  endtask

  // ----------------------------------------
  // Bits and bytes
  // ----------------------------------------
  // Data set in low phase, sampled mid high
  task automatic bit_cycle(input logic pull, output logic seen);
    sda_low_out = pull;
    wait_clk(5 + extra);
    scl_out = 1'b1;
    wait_clk(5 + extra);
    seen = sda_in;
    wait_clk(5 + extra);
    scl_out = 1'b0;
    wait_clk(5 + extra);
  endtask

  // Eight bits MSB first, then ack slot released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(~b[i], s);
    end
    bit_cycle(1'b0, s);
    ack = ~s;
  endtask

  // Eight bits in, then ack or withheld ack
  task automatic recv_byte(input logic give_ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b0, s);
      b[i] = s;
    end
    bit_cycle(give_ack, s);
  endtask
endmodule
`default_nettype wire

// *** verif/dual_mode_serial_eeprom_port_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module dual_mode_serial_eeprom_port_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [7:0] CW = {eeprom_port_pkg::DEVICE_TYPE_CODE, 4'h0};  // Write control
  localparam logic [7:0] CR = {eeprom_port_pkg::DEVICE_TYPE_CODE, 4'h1};  // Read control
  logic clk_in;
  logic reset_in;
  logic link_clk;        // Free running link clock
  logic link_run;        // Link clock gate
  logic write_en;        // Link pin level while gated
  logic scl;
  logic m_low;
  logic sda_out;
  logic sda_oe_n_out;
  logic bidir_mode_out;
  logic write_busy_out;
  wire  sda_w;           // Pulled up unless someone pulls low
  wire  transmit_only_clock;
  int   fail_count;
  int   checks_done;
  int   cycles;
  assign sda_w = !m_low && (sda_oe_n_out || sda_out);
  assign transmit_only_clock  = link_run ? link_clk : write_en;

  eeprom_dual_mode_port #(.WRITE_CYCLES(300)) i_dut (
    .clk_in(clk_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .transmit_only_clock_in(transmit_only_clock),
    .bidir_mode_out(bidir_mode_out), .write_busy_out(write_busy_out));
  two_wire_master_model i_master (
    .clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_low_out(m_low));

  // ----------------------------------------
  // Clocks and watchdog
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      results();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic put(input logic [7:0] b, input logic ack_exp);
    logic a;
    i_master.send_byte(b, a);
    chk("ack", 8'(a), 8'(ack_exp));
  endtask

  // Load the pointer through an abandoned write
  task automatic set_ptr(input logic [7:0] addr);
    i_master.start();
    put(CW, 1'b1);
    put(addr, 1'b1);
  endtask

  // Read n bytes, master acks all but the last
  task automatic rd(input int n, input logic [7:0] e [8]);
    logic [7:0] d;
    i_master.start();
    put(CR, 1'b1);
    for (int k = 0; k < n; k++) begin
      i_master.recv_byte(k != n - 1, d);
      chk("data", d, e[k]);
    end
    chk("release", 8'(sda_w), 8'h01);
    i_master.stop();
  endtask

  task automatic poll_done();
    logic a;
    a = 1'b0;
    for (int t = 0; t < 4 && !a; t++) begin
      i_master.start();
      i_master.send_byte(CW, a);
      i_master.stop();
    end
    chk("poll", 8'(a), 8'h01);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_stream();
    for (int k = 0; k < 9; k++) begin
      @(posedge transmit_only_clock);
      #4;
      chk("sync", 8'(sda_w), 8'h01);
    end
    chk("txmode", 8'(bidir_mode_out), 8'h00);
    $display("stream done");
  endtask

  task automatic t_mode();
    @(negedge clk_in);
    link_run = 1'b0;
    i_master.pulse_scl();
    chk("bidir", 8'(bidir_mode_out), 8'h01);
    chk("sda_out", 8'(sda_out), 8'h00);
    link_run = 1'b1;
    repeat (20) @(negedge clk_in);
    link_run = 1'b0;
    chk("sticky", {6'h00, bidir_mode_out, sda_w}, 8'h03);
    $display("mode done");
  endtask

  task automatic t_badcode();
    i_master.start();
    put(8'h30, 1'b0);
    i_master.stop();
    $display("badcode done");
  endtask

  task automatic t_page();
    i_master.start();
    put({eeprom_port_pkg::DEVICE_TYPE_CODE, 4'hE}, 1'b1);
    put(8'h9D, 1'b1);
    for (int k = 0; k < 10; k++) begin
      put(8'hA0 + 8'(k), 1'b1);
    end
    i_master.stop();
    chk("busy", 8'(write_busy_out), 8'h01);
    i_master.start();
    put(CW, 1'b0);
    i_master.stop();
    poll_done();
    $display("page done");
  endtask

  task automatic t_readback();
    set_ptr(8'h18);
    rd(6, '{8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'h00, 8'h00});
    rd(1, '{8'hA9, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    i_master.extra = 10;
    rd(1, '{8'hA2, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    i_master.extra = 0;
    $display("readback done");
  endtask

  task automatic t_protect();
    write_en = 1'b0;
    set_ptr(8'h18);
    put(8'h11, 1'b1);
    i_master.stop();
    chk("nobusy", 8'(write_busy_out), 8'h00);
    set_ptr(8'h18);
    rd(1, '{8'hA3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    write_en = 1'b1;
    $display("protect done");
  endtask

  task automatic t_wrap();
    set_ptr(8'hFF);
    put(8'h3C, 1'b1);
    i_master.stop();
    write_en = 1'b0;
    poll_done();
    write_en = 1'b1;
    set_ptr(8'h80);
    put(8'hC3, 1'b1);
    i_master.stop();
    poll_done();
    set_ptr(8'h7F);
    rd(2, '{8'h3C, 8'hC3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    $display("wrap done");
  endtask

  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    reset_in    = 1'b1;
    link_run    = 1'b1;
    write_en    = 1'b1;
    fail_count  = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (6) @(negedge clk_in);
    reset_in = 1'b0;
    t_stream();
    t_mode();
    t_badcode();
    t_page();
    t_readback();
    t_protect();
    t_wrap();
    results();
  end
endmodule
`default_nettype wire
